// ---- logic/pir_pkg.sv ----
`default_nettype none
package pir_pkg;
  // register pointer values in the expanded memory map
  localparam logic [15:0] PENDING0_ADDR = 16'h810d;
  localparam logic [15:0] PENDING1_ADDR = 16'h810e;
  localparam logic [15:0] CAPTURED0_ADDR = 16'h810f;
  localparam logic [15:0] CAPTURED1_ADDR = 16'h8110;
  localparam logic [15:0] LIVE0_ADDR = 16'h8111;
  localparam logic [15:0] LIVE1_ADDR = 16'h8112;
  localparam logic [15:0] ENABLE0_ADDR = 16'h8113;
  localparam logic [15:0] ENABLE1_ADDR = 16'h8114;
  localparam logic [15:0] CLEAR0_ADDR = 16'h8115;
  localparam logic [15:0] CLEAR1_ADDR = 16'h8116;
  localparam logic [15:0] CTRL_ADDR = 16'h8117;
  // reset values
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] PENDING1_RESET = 8'h01;
  // writable masks
  localparam logic [7:0] ENABLE1_WMASK = 8'h7f;
  localparam logic [7:0] CTRL_WMASK = 8'hff;
  // first flag group bit positions
  localparam int NEG_LIMIT_BIT = 7;
  localparam int NEG_DONE_BIT = 6;
  localparam int FAULT_BIT = 5;
  localparam int SPEED_BIT = 4;
  localparam int SPEED_LO = 3;
  localparam int LINK_LIMIT_BIT = 3;
  localparam int LINK_BIT = 2;
  localparam int DUPLEX_BIT = 1;
  localparam int JABBER_BIT = 0;
  // second flag group bit positions
  localparam int CFG_FAULT_BIT = 7;
  localparam int CFG_BIT = 6;
  localparam int LOC_RCVR_BIT = 5;
  localparam int REM_RCVR_BIT = 4;
  localparam int IDLE_LIMIT_BIT = 3;
  localparam int FW_ROM_BIT = 2;
  localparam int FW_RAM_BIT = 1;
  localparam int RESET_EV_BIT = 0;
  // output control bits
  localparam int CTRL_MODE_BIT = 2;
  localparam int CTRL_POL_BIT = 0;

  // monitored transceiver status, same clock as this block
  typedef struct packed {
    logic negotiationDone; // basic_status_reg negotiation complete
    logic partnerFaultFlag; // basic_status_reg remote fault
    logic link; // resolution_status_reg link
    logic [1:0] speed; // resolution_status_reg speed
    logic duplex; // resolution_status_reg duplex
    logic jabber; // basic_status_reg jabber
    logic cfgFault; // gigabit_status_reg config fault
    logic cfgMaster; // gigabit_status_reg bit 14
    logic locRcvr; // gigabit_status_reg local receiver ok
    logic remRcvr; // gigabit_status_reg remote receiver ok
  } pir_status_t;

  // one-cycle source events and firmware location levels
  typedef struct packed {
    logic negCountLimit; // negotiation count over threshold
    logic linkCountLimit; // link count over threshold
    logic idleErrLimit; // idle error count over threshold
    logic resetEvent; // firmware passed reset sequence
    logic fwRom; // firmware runs from rom (level)
    logic fwRam; // firmware runs from ram (level)
  } pir_events_t;
endpackage
`default_nettype wire

// ---- logic/pir_flag_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
module pir_flag_bank #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] setVec, // per-bit set request
  input wire logic [7:0] clrVec, // per-bit clear request
  output logic [7:0] flags_q // sticky flags
);
  // one sticky cell per bit; set beats clear so no event is lost
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_cell
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flags_q[i] <= RESET_VAL[i];
        end else if (setVec[i]) begin
          flags_q[i] <= 1'b1;
        end else if (clrVec[i]) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- logic/pir_reason_enable.sv ----
// Overview of operation
// - capture negotiation, fault, link, jabber at interrupt
// - capture speed at interrupt only if link
// - capture duplex at interrupt only if link
// - capture gigabit fault and receiver bits
// - capture bit14 status if link, low bits zero
// - live register shows current status bits
// - live speed holds last linked value
// - live duplex holds last linked value
// - second live register shows gigabit status
// - first enable register gates eight sources
// - second enable register gates seven sources
// - reset event source enabled by bit0
// - status flag set on monitored change
// - write one clears flag, clear self-resets
// - output driven when mode and indicators enabled
`timescale 1ns/100ps
`default_nettype none
module pir_reason_enable (
  input wire logic clk, // 100 MHz core clock
  input wire logic rst_n, // async reset, active low
  input wire pir_pkg::pir_status_t status, // live transceiver status
  input wire pir_pkg::pir_events_t events, // source events
  input wire logic ledEnable, // indicator outputs enabled
  input wire logic [15:0] memAddr, // expanded memory pointer value
  input wire logic memWr, // data register write strobe
  input wire logic memRd, // data register read strobe
  input wire logic [7:0] memWrData, // write byte
  output logic [7:0] memRdData_q, // read byte, valid cycle after memRd
  output logic irqOut, // interrupt pin level
  output logic irqOe, // interrupt pin drive enable
  output logic clrNegCount_q, // pulse: clear negotiation counter
  output logic clrLinkCount_q // pulse: clear link counters
);
  // registers
  logic [7:0] captured0_q; // captured reason, first
  logic [7:0] captured1_q; // captured reason, second
  logic [7:0] enable0_q; // source enable, first
  logic [7:0] enable1_q; // source enable, second
  logic [7:0] ctrl_q; // output control
  logic [7:0] pending0; // pending flags, first
  logic [7:0] pending1; // pending flags, second
  logic [7:0] live0; // live reason, first
  logic [7:0] live1; // live reason, second
  pir_pkg::pir_status_t prev_q; // status one cycle ago
  logic [1:0] lastSpeed_q; // speed while link was last up
  logic lastDuplex_q; // duplex while link was last up
  logic irqRaw; // any enabled flag pending
  logic irqRaw_q; // previous irqRaw for edge detect
  logic irqRise; // first cycle of interrupt
  logic [7:0] set0; // set requests, first
  logic [7:0] set1; // set requests, second
  logic [7:0] clr0; // clear requests, first
  logic [7:0] clr1; // clear requests, second
  logic wrClr0; // write to first clear register
  logic wrClr1; // write to second clear register

  // remember status for change detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '0;
    end else begin
      prev_q <= status;
    end
  end

  // hold speed and duplex across link loss
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastSpeed_q <= 2'h0;
      lastDuplex_q <= 1'h0;
    end else if (status.link) begin
      lastSpeed_q <= status.speed;
      lastDuplex_q <= status.duplex;
    end
  end

  // live reason views, reserved bits read zero
  always_comb begin
    live0 = pir_pkg::ZERO_BYTE;
    live0[pir_pkg::NEG_DONE_BIT] = status.negotiationDone;
    live0[pir_pkg::FAULT_BIT] = status.partnerFaultFlag;
    live0[pir_pkg::SPEED_BIT:pir_pkg::SPEED_LO] =
      status.link ? status.speed : lastSpeed_q;
    live0[pir_pkg::LINK_BIT] = status.link;
    live0[pir_pkg::DUPLEX_BIT] = status.link ? status.duplex : lastDuplex_q;
    live0[pir_pkg::JABBER_BIT] = status.jabber;
    live1 = pir_pkg::ZERO_BYTE;
    live1[pir_pkg::CFG_FAULT_BIT] = status.cfgFault;
    live1[pir_pkg::CFG_BIT] = status.cfgMaster & status.link;
    live1[pir_pkg::LOC_RCVR_BIT] = status.locRcvr;
    live1[pir_pkg::REM_RCVR_BIT] = status.remRcvr;
  end

  // change events; speed, duplex and bit14 only count while linked
  always_comb begin
    set0 = pir_pkg::ZERO_BYTE;
    set0[pir_pkg::NEG_LIMIT_BIT] = events.negCountLimit;
    set0[pir_pkg::NEG_DONE_BIT] = status.negotiationDone ^ prev_q.negotiationDone;
    set0[pir_pkg::FAULT_BIT] = status.partnerFaultFlag ^ prev_q.partnerFaultFlag;
    set0[pir_pkg::SPEED_BIT] = status.link && (status.speed != lastSpeed_q);
    set0[pir_pkg::LINK_LIMIT_BIT] = events.linkCountLimit;
    set0[pir_pkg::LINK_BIT] = status.link ^ prev_q.link;
    set0[pir_pkg::DUPLEX_BIT] = status.link && (status.duplex != lastDuplex_q);
    set0[pir_pkg::JABBER_BIT] = status.jabber ^ prev_q.jabber;
    set1 = pir_pkg::ZERO_BYTE;
    set1[pir_pkg::CFG_FAULT_BIT] = status.cfgFault ^ prev_q.cfgFault;
    set1[pir_pkg::CFG_BIT] = status.link && (status.cfgMaster ^ prev_q.cfgMaster);
    set1[pir_pkg::LOC_RCVR_BIT] = status.locRcvr ^ prev_q.locRcvr;
    set1[pir_pkg::REM_RCVR_BIT] = status.remRcvr ^ prev_q.remRcvr;
    set1[pir_pkg::IDLE_LIMIT_BIT] = events.idleErrLimit;
    set1[pir_pkg::RESET_EV_BIT] = events.resetEvent;
  end

  // clear registers act on the write itself and never store: reads give zero
  assign wrClr0 = memWr && (memAddr == pir_pkg::CLEAR0_ADDR);
  assign wrClr1 = memWr && (memAddr == pir_pkg::CLEAR1_ADDR);
  assign clr0 = wrClr0 ? memWrData : pir_pkg::ZERO_BYTE;
  assign clr1 = wrClr1 ? memWrData : pir_pkg::ZERO_BYTE;

  // sticky pending flags, set wins over clear
  logic [7:0] flags1_q; // stored second flags
  pir_flag_bank #(.RESET_VAL(pir_pkg::ZERO_BYTE)) u_flags0 (
    .clk(clk),
    .rst_n(rst_n),
    .setVec(set0),
    .clrVec(clr0),
    .flags_q(pending0)
  );
  pir_flag_bank #(.RESET_VAL(pir_pkg::PENDING1_RESET)) u_flags1 (
    .clk(clk),
    .rst_n(rst_n),
    .setVec(set1),
    .clrVec(clr1),
    .flags_q(flags1_q)
  );

  // firmware location bits are levels, not sticky
  always_comb begin
    pending1 = flags1_q;
    pending1[pir_pkg::FW_ROM_BIT] = events.fwRom;
    pending1[pir_pkg::FW_RAM_BIT] = events.fwRam;
  end

  // counter clear pulses ride along with the flag clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clrNegCount_q <= 1'b0;
      clrLinkCount_q <= 1'b0;
    end else begin
      clrNegCount_q <= clr0[pir_pkg::NEG_LIMIT_BIT];
      clrLinkCount_q <= clr0[pir_pkg::LINK_LIMIT_BIT];
    end
  end

  // enable and control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable0_q <= pir_pkg::ZERO_BYTE;
      enable1_q <= pir_pkg::ZERO_BYTE;
      ctrl_q <= pir_pkg::ZERO_BYTE;
    end else if (memWr) begin
      if (memAddr == pir_pkg::ENABLE0_ADDR) begin
        enable0_q <= memWrData;
      end
      if (memAddr == pir_pkg::ENABLE1_ADDR) begin
        enable1_q <= memWrData & pir_pkg::ENABLE1_WMASK;
      end
      if (memAddr == pir_pkg::CTRL_ADDR) begin
        ctrl_q <= memWrData & pir_pkg::CTRL_WMASK;
      end
    end
  end

  // interrupt request; bit0 of enable1 alone gates the reset event
  assign irqRaw = |(pending0 & enable0_q) | |(pending1 & enable1_q);
  assign irqRise = irqRaw && !irqRaw_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqRaw_q <= 1'b0;
    end else begin
      irqRaw_q <= irqRaw;
    end
  end

  // pin drive: off unless mode set and indicators on; polarity from ctrl
  assign irqOe = ctrl_q[pir_pkg::CTRL_MODE_BIT] && ledEnable;
  assign irqOut = irqOe ? (irqRaw ~^ ctrl_q[pir_pkg::CTRL_POL_BIT]) : 1'b0;

  // capture reasons on first cycle of interrupt; linked-only bits hold otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      captured0_q <= pir_pkg::ZERO_BYTE;
      captured1_q <= pir_pkg::ZERO_BYTE;
    end else if (irqRise) begin
      captured0_q[pir_pkg::NEG_DONE_BIT] <= status.negotiationDone;
      captured0_q[pir_pkg::FAULT_BIT] <= status.partnerFaultFlag;
      captured0_q[pir_pkg::LINK_BIT] <= status.link;
      captured0_q[pir_pkg::JABBER_BIT] <= status.jabber;
      if (status.link) begin
        captured0_q[pir_pkg::SPEED_BIT:pir_pkg::SPEED_LO] <= status.speed;
        captured0_q[pir_pkg::DUPLEX_BIT] <= status.duplex;
        captured1_q[pir_pkg::CFG_BIT] <= status.cfgMaster;
      end
      captured1_q[pir_pkg::CFG_FAULT_BIT] <= status.cfgFault;
      captured1_q[pir_pkg::LOC_RCVR_BIT] <= status.locRcvr;
      captured1_q[pir_pkg::REM_RCVR_BIT] <= status.remRcvr;
    end
  end

  // registered read port; software loads pointer then reads data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memRdData_q <= pir_pkg::ZERO_BYTE;
    end else if (memRd) begin
      case (memAddr)
        pir_pkg::PENDING0_ADDR: memRdData_q <= pending0;
        pir_pkg::PENDING1_ADDR: memRdData_q <= pending1;
        pir_pkg::CAPTURED0_ADDR: memRdData_q <= captured0_q;
        pir_pkg::CAPTURED1_ADDR: memRdData_q <= captured1_q;
        pir_pkg::LIVE0_ADDR: memRdData_q <= live0;
        pir_pkg::LIVE1_ADDR: memRdData_q <= live1;
        pir_pkg::ENABLE0_ADDR: memRdData_q <= enable0_q;
        pir_pkg::ENABLE1_ADDR: memRdData_q <= enable1_q;
        pir_pkg::CTRL_ADDR: memRdData_q <= ctrl_q;
        default: memRdData_q <= pir_pkg::ZERO_BYTE; // clear regs and unmapped
      endcase
    end
  end

  // checks
  property p_capFlags0;
    @(posedge clk) disable iff (!rst_n)
    irqRise |=> (captured0_q[pir_pkg::LINK_BIT] == $past(status.link)) &&
      (captured0_q[pir_pkg::JABBER_BIT] == $past(status.jabber));
  endproperty
  a_capFlags0: assert property (p_capFlags0) else $error("capture of link or jabber wrong");
  property p_capSpeed;
    @(posedge clk) disable iff (!rst_n)
    irqRise && status.link |=> captured0_q[pir_pkg::SPEED_BIT:pir_pkg::SPEED_LO] ==
      $past(status.speed);
  endproperty
  a_capSpeed: assert property (p_capSpeed) else $error("speed capture wrong");
  property p_capDuplexHold;
    @(posedge clk) disable iff (!rst_n)
    irqRise && !status.link |=> $stable(captured0_q[pir_pkg::DUPLEX_BIT]);
  endproperty
  a_capDuplexHold: assert property (p_capDuplexHold) else $error("duplex captured while down");
  property p_capGig;
    @(posedge clk) disable iff (!rst_n)
    irqRise |=> captured1_q[pir_pkg::CFG_FAULT_BIT] == $past(status.cfgFault);
  endproperty
  a_capGig: assert property (p_capGig) else $error("config fault capture wrong");
  property p_capLow;
    @(posedge clk) disable iff (!rst_n)
    irqRise |=> captured1_q[3:0] == 4'h0 && captured0_q[7] == 1'b0 &&
      captured1_q[pir_pkg::CFG_BIT] ==
      ($past(status.link) ? $past(status.cfgMaster) : $past(captured1_q[pir_pkg::CFG_BIT]));
  endproperty
  a_capLow: assert property (p_capLow) else $error("reserved or bit14 capture wrong");
  property p_liveHold;
    @(posedge clk) disable iff (!rst_n)
    !status.link ##1 !status.link |-> $stable(live0[pir_pkg::SPEED_BIT:pir_pkg::SPEED_LO]);
  endproperty
  a_liveHold: assert property (p_liveHold) else $error("live speed moved while down");
  property p_linkFlag;
    @(posedge clk) disable iff (!rst_n)
    (status.link != prev_q.link) |=> pending0[pir_pkg::LINK_BIT];
  endproperty
  a_linkFlag: assert property (p_linkFlag) else $error("link change not flagged");
  property p_clearFlag;
    @(posedge clk) disable iff (!rst_n)
    wrClr0 && memWrData[pir_pkg::LINK_BIT] && !set0[pir_pkg::LINK_BIT] |=>
      !pending0[pir_pkg::LINK_BIT];
  endproperty
  a_clearFlag: assert property (p_clearFlag) else $error("link flag not cleared");
  property p_irqLevel;
    @(posedge clk) disable iff (!rst_n)
    irqOe && (pending0 & enable0_q) != 8'h00 |-> irqOut == ctrl_q[pir_pkg::CTRL_POL_BIT];
  endproperty
  a_irqLevel: assert property (p_irqLevel) else $error("interrupt level wrong");
endmodule
`default_nettype wire

// ---- tb/pir_reason_enable_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module pir_reason_enable_bench;
  logic clk; // core clock
  logic rst_n; // async reset, active low
  pir_pkg::pir_status_t status; // monitored status levels
  pir_pkg::pir_events_t events; // source event pulses
  logic ledEnable; // indicator outputs enabled
  logic [15:0] memAddr; // register pointer
  logic memWr; // write strobe
  logic memRd; // read strobe
  logic [7:0] memWrData; // write byte
  logic [7:0] memRdData_q; // read byte
  logic irqOut; // interrupt pin level
  logic irqOe; // interrupt pin enable
  logic clrNegCount_q; // negotiation counter clear pulse
  logic clrLinkCount_q; // link counter clear pulse
  int fails; // mismatch count
  int checks; // comparison count
  logic [7:0] rdVal; // last byte read back
  logic [15:0] enaAddr [4]; // enable register of each event source
  logic [7:0] enaBit [4]; // enable bit of each event source

  pir_reason_enable i_dut (
    .clk(clk),
    .rst_n(rst_n),
    .status(status),
    .events(events),
    .ledEnable(ledEnable),
    .memAddr(memAddr),
    .memWr(memWr),
    .memRd(memRd),
    .memWrData(memWrData),
    .memRdData_q(memRdData_q),
    .irqOut(irqOut),
    .irqOe(irqOe),
    .clrNegCount_q(clrNegCount_q),
    .clrLinkCount_q(clrLinkCount_q)
  );

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // verdict and end of run, shared with the watchdog
  task automatic end_sim;
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // compare one byte and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // wait n edges, then land just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one data-register write; strobe dropped a full cycle before the next call
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    memAddr = a;
    memWrData = d;
    memWr = 1'b1;
    step(1);
    memWr = 1'b0;
    step(1);
  endtask

  // one data-register read; byte is ready the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    memAddr = a;
    memRd = 1'b1;
    step(1);
    memRd = 1'b0;
    rdVal = memRdData_q;
    step(1);
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    rd(a);
    chk(rdVal, exp);
  endtask

  // drop every pending flag so the next source starts from a quiet pin
  // the first clear write also checks the one-cycle counter clear pulses
  task automatic clrall;
    memAddr = pir_pkg::CLEAR0_ADDR;
    memWrData = 8'hff;
    memWr = 1'b1;
    step(1);
    chk({6'h00, clrNegCount_q, clrLinkCount_q}, 8'h03);
    memWr = 1'b0;
    step(1);
    chk({6'h00, clrNegCount_q, clrLinkCount_q}, 8'h00);
    wr(pir_pkg::CLEAR1_ADDR, 8'hff);
  endtask

  // hang guard, far beyond the roughly 150 cycles the tests need
  initial begin
    #200000;
    fails++;
    end_sim();
  end

  initial begin
    fails = 0;
    checks = 0;
    rst_n = 1'b0;
    status = '0;
    events = '0;
    ledEnable = 1'b1;
    memAddr = 16'h0000;
    memWr = 1'b0;
    memRd = 1'b0;
    memWrData = 8'h00;
    enaAddr = '{pir_pkg::ENABLE0_ADDR, pir_pkg::ENABLE0_ADDR,
                pir_pkg::ENABLE1_ADDR, pir_pkg::ENABLE1_ADDR};
    enaBit = '{8'h80, 8'h08, 8'h08, 8'h01};
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // reset values of captured, live and enable registers
    for (int i = 0; i < 6; i++) begin
      rchk(pir_pkg::CAPTURED0_ADDR + 16'(i), 8'h00);
    end
    rchk(pir_pkg::PENDING1_ADDR, 8'h01);
    // access kinds: enables writable, bit 7 of the second fixed, captured read-only
    wr(pir_pkg::ENABLE0_ADDR, 8'hff);
    rchk(pir_pkg::ENABLE0_ADDR, 8'hff);
    wr(pir_pkg::ENABLE1_ADDR, 8'hff);
    rchk(pir_pkg::ENABLE1_ADDR, 8'h7f);
    wr(pir_pkg::CAPTURED0_ADDR, 8'hff);
    rchk(pir_pkg::CAPTURED0_ADDR, 8'h00);
    rchk(16'h8120, 8'h00);
    wr(pir_pkg::ENABLE0_ADDR, 8'h00);
    wr(pir_pkg::ENABLE1_ADDR, 8'h00);
    // live view with link up, then link down keeps last linked speed and duplex
    status = 11'b1_1_1_10_1_1_1_1_1_1;
    step(2);
    rchk(pir_pkg::LIVE0_ADDR, 8'h77);
    rchk(pir_pkg::LIVE1_ADDR, 8'hf0);
    status = 11'b1_1_0_01_0_1_1_1_1_1;
    step(2);
    rchk(pir_pkg::LIVE0_ADDR, 8'h73);
    rchk(pir_pkg::LIVE1_ADDR, 8'hb0);
    // link-up interrupt captures the status of that moment
    clrall();
    wr(pir_pkg::ENABLE0_ADDR, 8'h04);
    wr(pir_pkg::CTRL_ADDR, 8'h05);
    chk({7'h00, irqOut}, 8'h00);
    status = 11'b0_1_1_11_1_0_0_1_1_0;
    step(3);
    chk({6'h00, irqOe, irqOut}, 8'h03);
    rchk(pir_pkg::CAPTURED0_ADDR, 8'h3e);
    rchk(pir_pkg::CAPTURED1_ADDR, 8'h60);
    wr(pir_pkg::CTRL_ADDR, 8'h04);
    chk({7'h00, irqOut}, 8'h00);
    wr(pir_pkg::CTRL_ADDR, 8'h05);
    wr(pir_pkg::CLEAR0_ADDR, 8'h04);
    chk({7'h00, irqOut}, 8'h00);
    rd(pir_pkg::PENDING0_ADDR);
    chk(rdVal & 8'h04, 8'h00);
    rchk(pir_pkg::CLEAR0_ADDR, 8'h00);
    // jabber interrupt with link down: speed, duplex and bit 14 stay as captured
    status = 11'b0_1_0_00_0_0_0_0_0_0;
    step(2);
    clrall();
    wr(pir_pkg::ENABLE0_ADDR, 8'h01);
    status = 11'b0_1_0_00_0_1_0_0_0_0;
    step(3);
    chk({7'h00, irqOut}, 8'h01);
    rchk(pir_pkg::CAPTURED0_ADDR, 8'h3b);
    rchk(pir_pkg::CAPTURED1_ADDR, 8'h40);
    // pin released when indicators off or interrupt mode off
    ledEnable = 1'b0;
    step(1);
    chk({6'h00, irqOe, irqOut}, 8'h00);
    ledEnable = 1'b1;
    wr(pir_pkg::CTRL_ADDR, 8'h01);
    chk({6'h00, irqOe, irqOut}, 8'h00);
    wr(pir_pkg::CTRL_ADDR, 8'h05);
    wr(pir_pkg::ENABLE0_ADDR, 8'h00);
    // each event source stays quiet until its own enable bit is set
    for (int k = 0; k < 4; k++) begin
      clrall();
      events = pir_pkg::pir_events_t'(6'h20 >> k);
      step(1);
      events = '0;
      step(2);
      chk({7'h00, irqOut}, 8'h00);
      wr(enaAddr[k], enaBit[k]);
      chk({7'h00, irqOut}, 8'h01);
      wr(enaAddr[k], 8'h00);
      chk({7'h00, irqOut}, 8'h00);
    end
    // reset in mid-run drops captured values, held speed and pin drive
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    chk({6'h00, irqOe, irqOut}, 8'h00);
    rchk(pir_pkg::CAPTURED0_ADDR, 8'h00);
    rchk(pir_pkg::LIVE0_ADDR, 8'h21);
    rchk(pir_pkg::PENDING1_ADDR, 8'h01);
    end_sim();
  end
endmodule
`default_nettype wire
